// ### logic/mce_pkg.sv
package mce_pkg;

    // ------------------------------------------------------------
    // bus geometry and register byte offsets
    // ------------------------------------------------------------
    localparam int unsigned AXI_AW      = 8;
    localparam int unsigned AXI_DW      = 32;
    localparam logic [7:0]  OFF_INSTR   = 8'h00;
    localparam logic [7:0]  OFF_WACC    = 8'h04;
    localparam logic [7:0]  OFF_STATUS  = 8'h08;
    localparam logic [7:0]  OFF_PC      = 8'h0C;
    localparam logic [7:0]  OFF_PAGE    = 8'h10;
    localparam logic [7:0]  OFF_STACK   = 8'h14;
    localparam logic [7:0]  OFF_FADDR   = 8'h18;
    localparam logic [7:0]  OFF_FDATA   = 8'h1C;
    localparam logic [7:0]  OFF_CTRL    = 8'h20;
    localparam logic [7:0]  OFF_COUNT   = 8'h24;

    // ------------------------------------------------------------
    // field positions, responses, reset values
    // ------------------------------------------------------------
    localparam int unsigned BIT_CARRY   = 0;
    localparam int unsigned BIT_DIGIT   = 1;
    localparam int unsigned BIT_ZERO    = 2;
    localparam int unsigned BIT_OVFL    = 3;
    localparam int unsigned BIT_BUSY    = 4;
    localparam int unsigned BIT_SKIPPED = 5;
    localparam int unsigned BIT_TBL_INT = 0;
    localparam int unsigned BIT_DEST    = 8;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam logic [1:0]  RESP_DECERR = 2'h3;
    localparam logic [15:0] PC_RESET    = 16'h0000;
    localparam logic [7:0]  WACC_RESET  = 8'h00;
    localparam logic [7:0]  PAGE_RESET  = 8'h00;
    localparam logic [7:0]  FILE_PC_LOW = 8'h02;

    // ------------------------------------------------------------
    // timing: four quarter phases of aclk make one instruction cycle
    // ------------------------------------------------------------
    localparam int unsigned CLK_NS      = 5;
    localparam int unsigned Q_PER_CYCLE = 4;
    localparam int unsigned ICYCLE_NS   = CLK_NS * Q_PER_CYCLE;
    localparam logic [1:0]  Q_LAST      = 2'(Q_PER_CYCLE - 1);
    localparam logic [1:0]  CYC_ONE     = 2'h1;
    localparam logic [1:0]  CYC_TWO     = 2'h2;
    localparam logic [1:0]  CYC_THREE   = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } mce_state_t;

    typedef enum logic [3:0] {
        OP_NONE, OP_ADD_LIT, OP_ADD_FILE, OP_ADD_FILE_C, OP_AND_LIT,
        OP_AND_FILE, OP_BIT_CLR, OP_BIT_SET, OP_SKIP_ZERO, OP_SKIP_ONE,
        OP_BIT_INV, OP_CALL, OP_FAR_CALL, OP_GOTO, OP_CLR_FILE, OP_TBL_RD
    } mce_op_t;

    // whole machine state, registered as one word
    typedef struct packed {
        mce_state_t       st;
        logic [1:0]       q;
        logic             first;
        logic [1:0]       cyc_left;
        logic             tw_hold;
        logic             is_tbl_wr;
        logic             skipped;
        logic [15:0]      ir;
        logic [7:0]       wacc;
        logic             carry;
        logic             digit_carry;
        logic             zero;
        logic             overflow;
        logic [15:0]      pc;
        logic [7:0]       page;
        logic [15:0]      stack_top;
        logic [7:0]       faddr;
        logic             tbl_int;
        logic [15:0]      icount;
        logic [255:0][7:0] mem;
        logic             evt_s1;
        logic             evt_s2;
        logic             aw_got;
        logic [7:0]       aw_addr;
        logic             w_got;
        logic [31:0]      wbuf;
        logic [3:0]       wstrb_q;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
    } mce_core_t;

endpackage

// ### logic/mce_exec.sv
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
// How it works
// - select bit set writes file only
// - far call: page latch high, literal low
// - table write internal waits event; external two
// - skip costs one extra no-operation cycle
// - branches two cycles; table read PC-low three
// - add literal into accumulator, four flags
// - add accumulator and file, d picks destination
// - add with carry, d picks destination
// - and literal into accumulator, zero only
// - and with file, d picks destination
// - clear selected file bit, no flags
// - set selected file bit, no flags
// - skip next when selected bit zero
// - skip next when selected bit one
// - invert selected file bit, no flags
// - in-page call pushes next, loads low 13
// - call refreshes page latch from literal, PC
module mce_exec (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // write address channel
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    // write data channel
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // write response channel
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // read address channel
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    // read data channel
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // core pins
    input  wire logic        table_stop_event,
    output logic             exec_busy,
    output logic [1:0]       q_phase
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic mce_pkg::mce_op_t decode(input logic [15:0] ir);
        casez (ir[15:8])
            8'b1011_0001: decode = mce_pkg::OP_ADD_LIT;
            8'b0000_111?: decode = mce_pkg::OP_ADD_FILE;
            8'b0001_000?: decode = mce_pkg::OP_ADD_FILE_C;
            8'b1011_0101: decode = mce_pkg::OP_AND_LIT;
            8'b0000_101?: decode = mce_pkg::OP_AND_FILE;
            8'b1000_1???: decode = mce_pkg::OP_BIT_CLR;
            8'b1000_0???: decode = mce_pkg::OP_BIT_SET;
            8'b1001_1???: decode = mce_pkg::OP_SKIP_ZERO;
            8'b1001_0???: decode = mce_pkg::OP_SKIP_ONE;
            8'b0011_1???: decode = mce_pkg::OP_BIT_INV;
            8'b111?_????: decode = mce_pkg::OP_CALL;
            8'b110?_????: decode = mce_pkg::OP_GOTO;
            8'b1011_0111: decode = mce_pkg::OP_FAR_CALL;
            8'b0010_100?: decode = mce_pkg::OP_CLR_FILE;
            8'b1010_10??: decode = mce_pkg::OP_TBL_RD;
            default:      decode = mce_pkg::OP_NONE;
        endcase
    endfunction

    // table writes share one class; they carry no file result
    function automatic logic is_tbl_write(input logic [15:0] ir);
        is_tbl_write = (ir[15:10] == 6'b1010_11);
    endfunction

    // instruction cycles before any skip or table stop is known
    function automatic logic [1:0] base_cycles(input logic [15:0] ir);
        case (decode(ir))
            mce_pkg::OP_CALL, mce_pkg::OP_GOTO,
            mce_pkg::OP_FAR_CALL: base_cycles = mce_pkg::CYC_TWO;
            mce_pkg::OP_TBL_RD: begin
                if (ir[7:0] == mce_pkg::FILE_PC_LOW) begin
                    base_cycles = mce_pkg::CYC_THREE;
                end else begin
                    base_cycles = mce_pkg::CYC_TWO;
                end
            end
            default: begin
                base_cycles = is_tbl_write(ir) ? mce_pkg::CYC_TWO : mce_pkg::CYC_ONE;
            end
        endcase
    endfunction

    // {overflow, carry, digit carry, zero, result}
    function automatic logic [11:0] add8(input logic [7:0] a, input logic [7:0] b,
                                         input logic ci);
        logic [4:0] lo;
        logic [8:0] full;
        lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        add8 = {(a[7] == b[7]) && (full[7] != a[7]), full[8], lo[4],
                full[7:0] == 8'h00, full[7:0]};
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            mce_pkg::OFF_INSTR, mce_pkg::OFF_WACC, mce_pkg::OFF_STATUS,
            mce_pkg::OFF_PC, mce_pkg::OFF_PAGE, mce_pkg::OFF_STACK,
            mce_pkg::OFF_FADDR, mce_pkg::OFF_FDATA, mce_pkg::OFF_CTRL,
            mce_pkg::OFF_COUNT: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] read_reg(input mce_pkg::mce_core_t c,
                                             input logic [7:0] a);
        case (a)
            mce_pkg::OFF_INSTR:  read_reg = {16'h0000, c.ir};
            mce_pkg::OFF_WACC:   read_reg = {24'h00_0000, c.wacc};
            mce_pkg::OFF_STATUS: read_reg = {26'h000_0000, c.skipped,
                                             c.st == mce_pkg::ST_EXEC, c.overflow,
                                             c.zero, c.digit_carry, c.carry};
            mce_pkg::OFF_PC:     read_reg = {16'h0000, c.pc};
            mce_pkg::OFF_PAGE:   read_reg = {24'h00_0000, c.page};
            mce_pkg::OFF_STACK:  read_reg = {16'h0000, c.stack_top};
            mce_pkg::OFF_FADDR:  read_reg = {24'h00_0000, c.faddr};
            mce_pkg::OFF_FDATA:  read_reg = {24'h00_0000, c.mem[c.faddr]};
            mce_pkg::OFF_CTRL:   read_reg = {31'h0000_0000, c.tbl_int};
            mce_pkg::OFF_COUNT:  read_reg = {16'h0000, c.icount};
            default:             read_reg = 32'h0000_0000;
        endcase
    endfunction

    // byte lanes not strobed keep the register's present value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    // ------------------------------------------------------------
    // state and working signals
    // ------------------------------------------------------------
    mce_pkg::mce_core_t s;
    mce_pkg::mce_core_t next_s;
    mce_pkg::mce_op_t   op;
    logic [7:0]         fval;
    logic [7:0]         bmask;
    logic [11:0]        sum;
    logic [7:0]         andv;
    logic [31:0]        merged;
    logic               skip_now;
    logic               commit;
    logic               done;

    assign op      = decode(s.ir);
    assign fval    = s.mem[s.ir[7:0]];
    assign bmask   = 8'h01 << s.ir[10:8];
    assign commit  = (s.st == mce_pkg::ST_EXEC) && (s.q == mce_pkg::Q_LAST) && s.first;
    assign done    = (s.st == mce_pkg::ST_EXEC) && (next_s.st == mce_pkg::ST_IDLE);
    assign awready = !s.aw_got && !s.bvalid;
    assign wready  = !s.w_got && !s.bvalid;
    assign arready = !s.rvalid;
    assign bvalid  = s.bvalid;
    assign bresp   = s.bresp;
    assign rvalid  = s.rvalid;
    assign rdata   = s.rdata;
    assign rresp   = s.rresp;
    assign exec_busy = (s.st == mce_pkg::ST_EXEC);
    assign q_phase   = s.q;

    // ------------------------------------------------------------
    // next state: bus slave first, execution after so it wins
    // ------------------------------------------------------------
    always_comb begin
        next_s   = s;
        sum      = add8(s.wacc, (op == mce_pkg::OP_ADD_LIT) ? s.ir[7:0] : fval,
                        (op == mce_pkg::OP_ADD_FILE_C) && s.carry);
        andv     = s.wacc & ((op == mce_pkg::OP_AND_LIT) ? s.ir[7:0] : fval);
        skip_now = ((op == mce_pkg::OP_SKIP_ZERO) && ((fval & bmask) == 8'h00)) ||
                   ((op == mce_pkg::OP_SKIP_ONE) && ((fval & bmask) != 8'h00));
        merged   = merge(read_reg(s, s.aw_addr), s.wbuf, s.wstrb_q);
        // the table stop event is a pin: two flops before use
        next_s.evt_s1 = table_stop_event;
        next_s.evt_s2 = s.evt_s1;

        if (awvalid && awready) begin
            next_s.aw_got  = 1'b1;
            next_s.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_s.w_got   = 1'b1;
            next_s.wbuf    = wdata;
            next_s.wstrb_q = wstrb;
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        // both halves held: perform the write and answer
        if (s.aw_got && s.w_got) begin
            next_s.aw_got = 1'b0;
            next_s.w_got  = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = is_mapped(s.aw_addr) ? mce_pkg::RESP_OKAY : mce_pkg::RESP_DECERR;
            case (s.aw_addr)
                mce_pkg::OFF_INSTR: begin
                    // a new word while busy would corrupt the running one
                    if (s.st == mce_pkg::ST_IDLE) begin
                        next_s.ir        = merged[15:0];
                        next_s.st        = mce_pkg::ST_EXEC;
                        next_s.q         = 2'h0;
                        next_s.first     = 1'b1;
                        next_s.skipped   = 1'b0;
                        next_s.cyc_left  = base_cycles(merged[15:0]);
                        next_s.is_tbl_wr = is_tbl_write(merged[15:0]);
                        next_s.tw_hold   = is_tbl_write(merged[15:0]) && s.tbl_int;
                        next_s.pc        = s.pc + 16'h0001;
                    end else begin
                        next_s.bresp = mce_pkg::RESP_SLVERR;
                    end
                end
                mce_pkg::OFF_WACC: next_s.wacc = merged[7:0];
                mce_pkg::OFF_STATUS: begin
                    next_s.carry       = merged[mce_pkg::BIT_CARRY];
                    next_s.digit_carry = merged[mce_pkg::BIT_DIGIT];
                    next_s.zero        = merged[mce_pkg::BIT_ZERO];
                    next_s.overflow    = merged[mce_pkg::BIT_OVFL];
                end
                mce_pkg::OFF_PC:    next_s.pc = merged[15:0];
                mce_pkg::OFF_PAGE:  next_s.page = merged[7:0];
                mce_pkg::OFF_FADDR: next_s.faddr = merged[7:0];
                mce_pkg::OFF_FDATA: next_s.mem[s.faddr] = merged[7:0];
                mce_pkg::OFF_CTRL:  next_s.tbl_int = merged[mce_pkg::BIT_TBL_INT];
                default: ;
            endcase
        end
        if (arvalid && arready) begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = read_reg(s, araddr);
            next_s.rresp  = is_mapped(araddr) ? mce_pkg::RESP_OKAY : mce_pkg::RESP_DECERR;
        end
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end

        // quarter-phase divider; Q4 is the instruction cycle's enable
        if (s.st == mce_pkg::ST_EXEC) begin
            next_s.q = s.q + 2'h1;
        end
        // results land at Q4 of the first instruction cycle
        if (commit) begin
            next_s.first = 1'b0;
            case (op)
                mce_pkg::OP_ADD_LIT: begin
                    next_s.wacc = sum[7:0];
                    {next_s.overflow, next_s.carry, next_s.digit_carry, next_s.zero} = sum[11:8];
                end
                mce_pkg::OP_ADD_FILE, mce_pkg::OP_ADD_FILE_C: begin
                    if (s.ir[mce_pkg::BIT_DEST]) begin
                        next_s.mem[s.ir[7:0]] = sum[7:0];
                    end else begin
                        next_s.wacc = sum[7:0];
                    end
                    {next_s.overflow, next_s.carry, next_s.digit_carry, next_s.zero} = sum[11:8];
                end
                mce_pkg::OP_AND_LIT: begin
                    next_s.wacc = andv;
                    next_s.zero = (andv == 8'h00);
                end
                mce_pkg::OP_AND_FILE: begin
                    if (s.ir[mce_pkg::BIT_DEST]) begin
                        next_s.mem[s.ir[7:0]] = andv;
                    end else begin
                        next_s.wacc = andv;
                    end
                    next_s.zero = (andv == 8'h00);
                end
                mce_pkg::OP_BIT_CLR: next_s.mem[s.ir[7:0]] = fval & ~bmask;
                mce_pkg::OP_BIT_SET: next_s.mem[s.ir[7:0]] = fval | bmask;
                mce_pkg::OP_BIT_INV: next_s.mem[s.ir[7:0]] = fval ^ bmask;
                mce_pkg::OP_CALL: begin
                    next_s.stack_top = s.pc;
                    next_s.pc[12:0]  = s.ir[12:0];
                    next_s.page      = {s.pc[15:13], s.ir[12:8]};
                end
                mce_pkg::OP_FAR_CALL: begin
                    next_s.stack_top = s.pc;
                    next_s.pc        = {s.page, s.ir[7:0]};
                end
                mce_pkg::OP_GOTO: next_s.pc[12:0] = s.ir[12:0];
                mce_pkg::OP_CLR_FILE: begin
                    next_s.mem[s.ir[7:0]] = 8'h00;
                    if (!s.ir[mce_pkg::BIT_DEST]) begin
                        next_s.wacc = 8'h00;
                    end
                end
                default: ;
            endcase
            if (skip_now) begin
                next_s.pc = s.pc + 16'h0001;
            end
        end
        // end of an instruction cycle: count down, hold or finish
        if ((s.st == mce_pkg::ST_EXEC) && (s.q == mce_pkg::Q_LAST)) begin
            if (s.tw_hold && !s.evt_s2) begin
                next_s.cyc_left = s.cyc_left;
            end else if (s.first && skip_now) begin
                next_s.skipped = 1'b1;
            end else if (s.cyc_left == mce_pkg::CYC_ONE) begin
                next_s.st     = mce_pkg::ST_IDLE;
                next_s.icount = s.icount + 16'h0001;
            end else begin
                next_s.cyc_left = s.cyc_left - 2'h1;
            end
            if (s.tw_hold && s.evt_s2) begin
                next_s.tw_hold = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // the one state register
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s      <= '0;
            s.st   <= mce_pkg::ST_IDLE;
            s.pc   <= mce_pkg::PC_RESET;
            s.wacc <= mce_pkg::WACC_RESET;
            s.page <= mce_pkg::PAGE_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [7:0] len;

    // clocks spent in the current instruction, for length checks
    always_ff @(posedge aclk) begin
        if (!aresetn || !exec_busy) begin
            len <= 8'h00;
        end else begin
            len <= len + 8'h01;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_skip_length: assert property (
        done && (op == mce_pkg::OP_SKIP_ZERO || op == mce_pkg::OP_SKIP_ONE)
        |-> len == (s.skipped ? 8'h07 : 8'h03))
        else $error("skip instruction length wrong");
    a_branch_length: assert property (
        done && (op == mce_pkg::OP_CALL || op == mce_pkg::OP_GOTO ||
                 op == mce_pkg::OP_FAR_CALL) |-> len == 8'h07)
        else $error("branch not two cycles");
    a_table_rd_len: assert property (
        done && op == mce_pkg::OP_TBL_RD
        |-> len == ((s.ir[7:0] == mce_pkg::FILE_PC_LOW) ? 8'h0B : 8'h07))
        else $error("table read length wrong");
    a_table_wr_ext: assert property (
        done && s.is_tbl_wr && !s.tbl_int |-> len == 8'h07)
        else $error("external table write not two cycles");
    a_table_wr_hold: assert property (
        exec_busy && s.tw_hold && !s.evt_s2 |=> exec_busy [*3])
        else $error("internal table write ended without event");
    a_far_call_pc: assert property (
        done && op == mce_pkg::OP_FAR_CALL |-> s.pc == {s.page, s.ir[7:0]})
        else $error("far call target wrong");
    a_call_latch: assert property (
        done && op == mce_pkg::OP_CALL |-> s.pc[12:0] == s.ir[12:0] &&
        s.page == {s.pc[15:13], s.ir[12:8]} && s.stack_top == $past(s.pc, 7))
        else $error("call target, latch or push wrong");
    a_add_lit_sum: assert property (
        commit && op == mce_pkg::OP_ADD_LIT
        |=> {s.carry, s.wacc} == 9'($past({1'b0, s.wacc}) + $past({1'b0, s.ir[7:0]})))
        else $error("literal add sum or carry wrong");
    a_dest_select: assert property (
        commit && s.ir[mce_pkg::BIT_DEST] && (op == mce_pkg::OP_ADD_FILE ||
        op == mce_pkg::OP_AND_FILE || op == mce_pkg::OP_CLR_FILE) |=> $stable(s.wacc))
        else $error("file-only destination touched accumulator");
    a_and_zero: assert property (
        commit && op == mce_pkg::OP_AND_LIT
        |=> s.zero == (s.wacc == 8'h00) && $stable(s.carry) && $stable(s.overflow))
        else $error("literal and flags wrong");
    a_bit_no_flags: assert property (
        commit && (op == mce_pkg::OP_BIT_CLR || op == mce_pkg::OP_BIT_SET ||
        op == mce_pkg::OP_BIT_INV) |=> $stable({s.carry, s.digit_carry, s.zero, s.overflow}))
        else $error("bit operation changed flags");

    c_add_done:   cover property (done && op == mce_pkg::OP_ADD_LIT);
    c_skip_taken: cover property (done && s.skipped);
    c_call_done:  cover property (done && op == mce_pkg::OP_CALL);
    c_tbl_stop:   cover property (s.tw_hold && s.evt_s2);

endmodule

// ### verif/tb_mcu_core_instr_exec_subset.sv
`timescale 1ns/1ps
module tb_mcu_core_instr_exec_subset;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
    logic        bready = 0, rready = 0, table_stop_event = 0;
    logic        awready, wready, bvalid, arready, rvalid, exec_busy;
    logic [7:0]  awaddr = 0, araddr = 0, w, m, k, fa;
    logic [31:0] wdata = 0, rdata, rd;
    logic [3:0]  wstrb = 4'hf, st = 0;
    logic [2:0]  b;
    logic [1:0]  bresp, rresp, q_phase, br;
    logic [15:0] p;
    int          err_total = 0, n_tests = 0, cyc, n;

    mce_exec dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .table_stop_event, .exec_busy, .q_phase);

    // 5 ns clock
    initial forever #2.5 aclk = ~aclk;

    // ------------------------------------------------------------
    // checking, bus tasks, expectations
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t seen %h wanted %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("mismatches %0d compares %0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // a wait that ran out ends the run
    task automatic lim();
        err_total += int'(cyc >= 200);
        if (cyc >= 200) stop_test();
    endtask
    // ready read right after the edge still shows the sampled value
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        for (cyc = 0; cyc < 200 && !(cyc > 0 && bvalid); cyc++) begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end
        br = bresp;
        bready <= 0;
        @(posedge aclk);
        lim();
    endtask
    task automatic rdr(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        for (cyc = 0; cyc < 200 && !(cyc > 0 && rvalid); cyc++) begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end
        rd = rdata;
        br = rresp;
        rready <= 0;
        @(posedge aclk);
        lim();
    endtask
    // n counts busy clocks; four clocks make one instruction cycle
    task automatic ex(input logic [15:0] i, input int c);
        wr(mce_pkg::OFF_INSTR, {16'h0, i});
        chk(br, mce_pkg::RESP_OKAY);
        for (n = 0; exec_busy === 1'b1 && n < 200; n++) @(posedge aclk);
        cyc = n;
        lim();
        chk({exec_busy, q_phase}, 0);
        if (c > 0) chk((n + 3) / 4, c);
    endtask
    // e = {overflow, zero, digit carry, carry, result}; d steers result to the file
    task automatic put(input logic [11:0] e, input logic d, input logic [15:0] i);
        ex(i, 1);
        st = e[11:8];
        if (d) m = e[7:0];
        else w = e[7:0];
    endtask
    function automatic logic [11:0] add8(input logic [7:0] a, c, input logic ci);
        logic [8:0] r;
        logic [4:0] h;
        r = a + c + ci;
        h = a[3:0] + c[3:0] + ci;
        return {a[7] == c[7] && r[7] != a[7], r[7:0] == 8'h0, h[4], r[8], r[7:0]};
    endfunction

    // reset, random arithmetic and bit ops, then the branch timings
    initial begin
        void'($urandom(32'hf35b_d957));
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rdr(mce_pkg::OFF_PC);
        chk(rd, 0);
        rdr(8'hfc);
        chk(br, mce_pkg::RESP_DECERR);
        fa = 8'($urandom);
        wr(mce_pkg::OFF_FADDR, {24'h0, fa});
        repeat (10) begin
            {w, m, k, b} = 27'($urandom);
            wr(mce_pkg::OFF_WACC, {24'h0, w});
            wr(mce_pkg::OFF_FDATA, {24'h0, m});
            put(add8(w, k, 0), 0, {8'hb1, k});
            put(add8(w, m, 0), k[0], {7'h07, k[0], fa});
            put(add8(w, m, st[0]), k[1], {7'h08, k[1], fa});
            put({st[3], (w & k) == 8'h0, st[1:0], w & k}, 0, {8'hb5, k});
            put({st[3], (w & m) == 8'h0, st[1:0], w & m}, k[2], {7'h05, k[2], fa});
            put({st, m & ~(8'h1 << b)}, 1, {5'h11, b, fa});
            put({st, m | (8'h1 << b)}, 1, {5'h10, b, fa});
            put({st, m ^ (8'h1 << b)}, 1, {5'h07, b, fa});
            rdr(mce_pkg::OFF_FDATA);
            chk(rd, {24'h0, m});
            rdr(mce_pkg::OFF_WACC);
            chk(rd, {24'h0, w});
            rdr(mce_pkg::OFF_STATUS);
            chk(rd[3:0], st);
            rdr(mce_pkg::OFF_PC);
            p = rd[15:0] + 16'(k[3] ^ m[b]) + 16'h1;
            ex({4'h9, k[3], b, fa}, 1 + int'(k[3] ^ m[b]));
            rdr(mce_pkg::OFF_PC);
            chk(rd, {16'h0, p});
            rdr(mce_pkg::OFF_STATUS);
            chk(rd[5], k[3] ^ m[b]);
            ex({7'h14, k[4], fa}, 1);
            m = 0;
            w = k[4] ? w : 8'h0;
            rdr(mce_pkg::OFF_WACC);
            chk(rd, {24'h0, w});
            rdr(mce_pkg::OFF_FDATA);
            chk(rd, {24'h0, m});
        end
        wr(mce_pkg::OFF_PC, 32'h0000_a123);
        ex(16'hf5a7, 2);
        rdr(mce_pkg::OFF_STACK);
        chk(rd, 32'h0000_a124);
        rdr(mce_pkg::OFF_PAGE);
        chk(rd, 32'h0000_00b5);
        ex({8'hb7, k}, 2);
        rdr(mce_pkg::OFF_PC);
        chk(rd, {16'h0, 8'hb5, k});
        ex(16'hd0ff, 2);
        ex(16'ha802, 3);
        ex(16'ha810, 2);
        ex(16'hac00, 2);
        wr(mce_pkg::OFF_CTRL, 32'h1);
        fork
            ex(16'hac00, 0);
            begin
                repeat (40) @(posedge aclk);
                table_stop_event <= 1;
            end
        join
        chk(n > 36 && n < 64, 1);
        stop_test();
    end
endmodule
